// ==== bench/dcp_ctrl_model.sv ====
// memory controller model that sends clock enable and commands
`timescale 1ns/1ps
`default_nettype none
module dcp_ctrl_model
  import dcp_pkg::*;
(
  // clock
  input  wire logic       ref_clk_i,
  // requests
  input  wire logic       cke_req_i,
  input  wire logic [3:0] cmd_req_i,
  // link
  output logic            cke_o,
  output logic [3:0]      cmd_o
);
  logic cke_last = 1'b1;
  always_ff @(posedge ref_clk_i) cke_last <= cke_o;
  // requests keep three-clock cke periods and defined combinations, except one cke fall requested while busy
  assign cke_o = cke_req_i;
  // nop on every enable change except refresh on a falling enable
  assign cmd_o = (cke_o != cke_last && !(cmd_req_i == DCP_CMD_REFRESH && !cke_o))
    ? DCP_CMD_NOP : cmd_req_i;
endmodule : dcp_ctrl_model
`default_nettype wire

// ==== bench/dcp_power_sva.sv ====
// assertions on the power-state block ports
`timescale 1ns/1ps
`default_nettype none
module dcp_power_sva
  import dcp_pkg::*;
(
  input wire logic          ref_clk_i,
  input wire logic          sys_rst_i,
  input wire logic          cke_i,
  input wire logic          cs_n_i,
  input wire logic          ras_n_i,
  input wire logic          cas_n_i,
  input wire logic          we_n_i,
  input wire logic          any_bank_open_i,
  input wire logic          op_busy_i,
  input wire logic          clk_changed_i,
  input wire logic          dll_reset_needed_o,
  input wire dcp_state_type power_state_o,
  input wire logic          refresh_allowed_o,
  input wire logic          odt_enable_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  wire logic [3:0] cmd = {cs_n_i, ras_n_i, cas_n_i, we_n_i};
  wire logic nop = cs_n_i || cmd == DCP_CMD_NOP;
  wire logic norm = power_state_o == DCP_NORMAL;
  wire logic ent = norm && !cke_i && !op_busy_i;
  a_prechg_entry: assert property (ent && $past(cke_i) && nop && !any_bank_open_i
    |=> power_state_o == DCP_PRECHG_PD) else $error("precharge entry missed");
  a_active_entry: assert property (ent && $past(cke_i) && nop && any_bank_open_i
    |=> power_state_o == DCP_ACTIVE_PD) else $error("active entry missed");
  a_self_entry: assert property (ent && $past(cke_i) && cmd == DCP_CMD_REFRESH
    && !any_bank_open_i |=> power_state_o == DCP_SELF_REF) else $error("self entry missed");
  a_busy_refuse: assert property (norm && $past(cke_i) && !cke_i && op_busy_i
    |=> norm) else $error("entry while busy");
  a_exit_normal: assert property (!norm && cke_i && nop |=> norm) else $error("exit missed");
  a_hold_low: assert property (!norm && !cke_i |=> $stable(power_state_o))
    else $error("state moved while low");
  a_no_refresh: assert property (!norm && power_state_o != DCP_SELF_REF
    |-> !refresh_allowed_o) else $error("refresh in power-down");
  a_odt_self: assert property (power_state_o == DCP_SELF_REF |-> !odt_enable_o)
    else $error("termination in self refresh");
  a_dll_set: assert property (power_state_o == DCP_PRECHG_PD && clk_changed_i
    |=> dll_reset_needed_o) else $error("clock change not recorded");
  a_odt_relock: assert property (dll_reset_needed_o |-> !odt_enable_o)
    else $error("termination before relock");
  c_clk_change: cover property (dll_reset_needed_o ##1 !dll_reset_needed_o);
  c_self_exit: cover property (power_state_o == DCP_SELF_REF ##1 norm);
  c_active: cover property (power_state_o == DCP_ACTIVE_PD);
  c_prechg: cover property (power_state_o == DCP_PRECHG_PD ##1 norm);
endmodule : dcp_power_sva
bind dcp_power_ctrl dcp_power_sva i_sva (.*);
`default_nettype wire

// ==== bench/tb.sv ====
// self-checking bench for the power-state block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dcp_pkg::*;
  logic clk = 0, rst = 1, cke = 1, odt = 1, open_r = 0, busy = 0, cke_w, cmd_en, read_ok;
  logic chg = 0, dll, odt_en;
  logic [3:0] cmd = DCP_CMD_NOP, cmd_w;
  dcp_state_type st;
  int error_cnt = 0, comparisons = 0, n = 0;
  // {cke, command, bank open, busy, expected state}
  logic [8:0] rows [24] = '{9'h170, 9'h170, 9'h072, 9'h072, 9'h052, 9'h170, 9'h170, 9'h130,
    9'h079, 9'h079, 9'h079, 9'h178, 9'h170, 9'h170, 9'h074, 9'h074, 9'h074, 9'h170, 9'h170,
    9'h170, 9'h013, 9'h073, 9'h073, 9'h170};
  initial forever #10 clk = ~clk;
  dcp_ctrl_model i_ctrl (.ref_clk_i(clk), .cke_req_i(cke), .cmd_req_i(cmd), .cke_o(cke_w),
    .cmd_o(cmd_w));
  dcp_power_ctrl #(.XSRD_CLOCKS(4), .XSNR_CLOCKS(4), .RELOCK_CLOCKS(4)) i_dut (
    .ref_clk_i(clk), .sys_rst_i(rst), .cke_i(cke_w), .cs_n_i(cmd_w[3]), .ras_n_i(cmd_w[2]),
    .cas_n_i(cmd_w[1]), .we_n_i(cmd_w[0]), .odt_i(odt), .any_bank_open_i(open_r),
    .op_busy_i(busy), .clk_changed_i(chg), .power_state_o(st), .cmd_enable_o(cmd_en),
    .refresh_allowed_o(), .odt_enable_o(odt_en), .read_allowed_o(read_ok),
    .non_read_allowed_o(), .dll_reset_needed_o(dll), .illegal_o());
  task automatic chk(input logic [1:0] got, input logic [1:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report;
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  initial begin
    repeat (2) @(posedge clk);
    @(negedge clk) rst = 0;
    chk(st, DCP_NORMAL);
    foreach (rows[i]) begin
      @(negedge clk) {cke, cmd, open_r, busy} = rows[i][8:2];
      @(posedge clk) #1;
      chk(st, rows[i][1:0]);
    end
    chk({1'b0, read_ok}, 2'h0);
    chk({1'b0, cmd_en}, 2'h0);
    while (read_ok !== 1'b1 && n < 10) begin
      @(posedge clk) #1;
      n++;
    end
    chk({1'b0, n == 4}, 2'h1);
    @(negedge clk) cke = 0;
    @(negedge clk) chg = 1;
    @(negedge clk) chg = 0;
    @(negedge clk) cke = 1;
    @(posedge clk) #1;
    chk({1'b0, dll}, 2'h1);
    @(negedge clk) cmd = DCP_CMD_LMODE;
    @(posedge clk) #1;
    chk({1'b0, dll | odt_en}, 2'h0);
    @(negedge clk) cmd = DCP_CMD_NOP;
    repeat (4) @(posedge clk);
    #1;
    chk({1'b0, odt_en}, 2'h1);
    final_report();
  end
endmodule : tb
`default_nettype wire

// ==== src/dcp_cnt.sv ====
// down counter that reports when a loaded interval has elapsed
`timescale 1ns/1ps
`default_nettype none
module dcp_cnt #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             sys_rst_i,
  // control
  input  wire logic             load_i,
  input  wire logic [WIDTH-1:0] value_i,
  // status
  output logic                  busy_o
);
  logic [WIDTH-1:0] count;

  assign busy_o = (count != '0);

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      count <= '0;
    end else if (load_i) begin
      count <= value_i;
    end else if (busy_o) begin
      count <= count - 1'b1;
    end
  end
endmodule : dcp_cnt
`default_nettype wire

// ==== src/dcp_pkg.sv ====
// constants and types for the clock-enable power-state block
// What the datasheet requires
// (R1) sample cke each edge; act on previous sample, current sample and command
// (R2) controller gives only nop or deselect on power-down entry and exit edges
// (R3) entry with all banks idle is precharge power-down, else active power-down
// (R4) self refresh entered only on cke high-to-low with refresh, all banks idle
// (R5) controller gives only nop or deselect on the self refresh exit edge
// (R6) after self refresh exit, only nop or deselect until exit-to-non-read time
// (R7) after self refresh exit, no read before 200 clocks
// (R8) no refresh is performed in either power-down mode
// (R9) commands ignored in power-down and self refresh; odt driven when enabled
// (R10) termination unavailable throughout self refresh regardless of odt
// (R11) controller uses only defined state, cke and command combinations
// (R12) no power-down entry while read, write, load mode or precharge runs
// (R13) every cke high and low period lasts at least three clocks
// (R14) power-down entry only after a read burst completes, earliest next edge
// (R15) write auto precharge starts after write recovery; entry one clock later
// (R16) write-recovery field in mode bits 9 to 11 is rounded-up clocks
// (R17) power-down entry accepted one clock after refresh, activate or precharge
// (R18) load mode needs banks precharged; power-down entry only after mode-set time
// (R19) clock frequency changes only in precharge power-down, two clocks after cke low
// (R20) odt and cke held low during frequency change, frequency within range
// (R21) new clock stable before exit; delay-locked loop reset after exit
// (R22) termination off during 200-cycle relock after a frequency change
// (R23) further mode loads advised after frequency change for latencies
// (R24) power-state register, reset to normal, records the four states
package dcp_pkg;

  typedef enum logic [1:0] {
    DCP_NORMAL     = 2'b00,
    DCP_ACTIVE_PD  = 2'b01,
    DCP_PRECHG_PD  = 2'b10,
    DCP_SELF_REF   = 2'b11
  } dcp_state_type;

  // command encoding {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] DCP_CMD_NOP     = 4'h7;
  localparam logic [3:0] DCP_CMD_REFRESH = 4'h1;
  localparam logic [3:0] DCP_CMD_ACT     = 4'h3;
  localparam logic [3:0] DCP_CMD_PRE     = 4'h2;
  localparam logic [3:0] DCP_CMD_READ    = 4'h5;
  localparam logic [3:0] DCP_CMD_WRITE   = 4'h4;
  localparam logic [3:0] DCP_CMD_LMODE   = 4'h0;

  localparam int DCP_XSRD_CLOCKS  = 200;
  localparam int DCP_XSNR_CLOCKS  = 200;
  localparam int DCP_RELOCK_CLOCKS = 200;
  localparam int DCP_CKE_MIN_CLOCKS = 3;

endpackage : dcp_pkg

// ==== src/dcp_power_ctrl.sv ====
// clock-enable power-state logic of the memory device
`timescale 1ns/1ps
`default_nettype none
module dcp_power_ctrl
  import dcp_pkg::*;
#(
  parameter int XSRD_CLOCKS   = DCP_XSRD_CLOCKS,
  parameter int XSNR_CLOCKS   = DCP_XSNR_CLOCKS,
  parameter int RELOCK_CLOCKS = DCP_RELOCK_CLOCKS
) (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        sys_rst_i,
  // link inputs
  input  wire logic        cke_i,
  input  wire logic        cs_n_i,
  input  wire logic        ras_n_i,
  input  wire logic        cas_n_i,
  input  wire logic        we_n_i,
  input  wire logic        odt_i,
  // core status from the bank and burst logic
  input  wire logic        any_bank_open_i,
  input  wire logic        op_busy_i,
  input  wire logic        clk_changed_i,
  // power state
  output dcp_state_type    power_state_o,
  output logic             cmd_enable_o,
  output logic             refresh_allowed_o,
  output logic             odt_enable_o,
  output logic             read_allowed_o,
  output logic             non_read_allowed_o,
  output logic             dll_reset_needed_o,
  output logic             illegal_o
);
  dcp_state_type state;
  dcp_state_type next_state;
  logic          cke_prev;
  logic          illegal;
  logic          dll_reset_needed;
  logic          relock_pending;

  wire [3:0] cmd      = {cs_n_i, ras_n_i, cas_n_i, we_n_i};
  wire       cmd_idle = cs_n_i | (cmd == DCP_CMD_NOP);
  wire       fall     = cke_prev & ~cke_i; // R1
  wire       rise     = ~cke_prev & cke_i; // R1
  wire       in_pd    = (state == DCP_ACTIVE_PD) || (state == DCP_PRECHG_PD);
  wire       in_sr    = (state == DCP_SELF_REF);
  wire       sr_entry = fall & (cmd == DCP_CMD_REFRESH) & ~any_bank_open_i & ~op_busy_i; // R4
  wire       pd_entry = fall & cmd_idle & ~op_busy_i; // R12 R14 R15 R17
  wire       sr_exit  = in_sr & rise & cmd_idle; // R5
  wire       pd_exit  = in_pd & rise & cmd_idle; // R2
  wire       xsnr_busy;
  wire       xsrd_busy;
  wire       relock_busy;

  // interval timers after self refresh exit and after a frequency change
  dcp_cnt #(.WIDTH(16)) u_xsnr (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .load_i    (sr_exit),
    .value_i   (16'(XSNR_CLOCKS)),
    .busy_o    (xsnr_busy)
  ); // R6
  dcp_cnt #(.WIDTH(16)) u_xsrd (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .load_i    (sr_exit),
    .value_i   (16'(XSRD_CLOCKS)),
    .busy_o    (xsrd_busy)
  ); // R7
  dcp_cnt #(.WIDTH(16)) u_relock (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .load_i    (relock_pending & cmd_enable_o & (cmd == DCP_CMD_LMODE)),
    .value_i   (16'(RELOCK_CLOCKS)),
    .busy_o    (relock_busy)
  ); // R22

  always_comb begin
    next_state = state;
    case (state)
      DCP_NORMAL: begin
        if (sr_entry) begin
          next_state = DCP_SELF_REF; // R4
        end else if (pd_entry) begin
          next_state = any_bank_open_i ? DCP_ACTIVE_PD : DCP_PRECHG_PD; // R3
        end
      end
      DCP_ACTIVE_PD, DCP_PRECHG_PD: begin
        if (pd_exit) begin
          next_state = DCP_NORMAL;
        end
      end
      DCP_SELF_REF: begin
        if (sr_exit) begin
          next_state = DCP_NORMAL;
        end
      end
      default: next_state = DCP_NORMAL;
    endcase
  end

  // combinations outside the defined table are flagged
  wire bad_now = (in_pd | in_sr) ? (rise & ~cmd_idle)
               : (fall & ~sr_entry & ~pd_entry); // R11

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      state    <= DCP_NORMAL; // R24
      cke_prev <= 1'b1;
      illegal  <= 1'b0;
    end else begin
      state    <= next_state; // R1 R24
      cke_prev <= cke_i; // R1
      illegal  <= bad_now;
    end
  end

  // frequency change in precharge power-down forces a delay-locked loop reset
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      dll_reset_needed <= 1'b0;
      relock_pending   <= 1'b0;
    end else if ((state == DCP_PRECHG_PD) & clk_changed_i) begin
      dll_reset_needed <= 1'b1; // R19 R21
      relock_pending   <= 1'b1;
    end else if (relock_pending & cmd_enable_o & (cmd == DCP_CMD_LMODE)) begin
      dll_reset_needed <= 1'b0; // R21
      relock_pending   <= 1'b0;
    end
  end

  assign power_state_o      = state;
  assign cmd_enable_o       = (state == DCP_NORMAL) & cke_i & ~xsnr_busy; // R9
  assign refresh_allowed_o  = ~in_pd; // R8
  assign odt_enable_o       = odt_i & ~in_sr & ~relock_busy & ~relock_pending; // R10 R22
  assign read_allowed_o     = cmd_enable_o & ~xsrd_busy; // R7
  assign non_read_allowed_o = cmd_enable_o; // R6
  assign dll_reset_needed_o = dll_reset_needed;
  assign illegal_o          = illegal;
endmodule : dcp_power_ctrl
`default_nettype wire
